// ===== dv/ccap_ext_model.sv
// far side model: module lines, external count input, oscillator tick
`timescale 1ns/1ps
module ccap_ext_model (
  input wire logic clk,
  output logic external_count_input,
  output logic osc,
  output logic [2:0] line
);
  int eci_cnt = 0;
  int osc_cnt = 0;
  initial begin
    external_count_input = 1'b1;
    osc = 1'b0;
    line = 3'h0;
  end
  // period of eight system clocks, below the quarter-rate limit
  always @(posedge clk) begin
    eci_cnt <= (eci_cnt == 3) ? 0 : eci_cnt + 1;
    if (eci_cnt == 3)
      external_count_input <= ~external_count_input;
  end
  // period of ten clocks, out of step with the count input
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
    if (osc_cnt == 4)
      osc <= ~osc;
  end
  task automatic set_line(input int n, input logic v);
    @(posedge clk);
    line[n] <= v;
    repeat (3) @(posedge clk);
  endtask
  // one-clock pulse, too short to count
  task automatic glitch(input int n);
    @(posedge clk);
    line[n] <= ~line[n];
    @(posedge clk);
    line[n] <= ~line[n];
    repeat (3) @(posedge clk);
  endtask
endmodule // ccap_ext_model

// ===== dv/tb_ccap_top.sv
// self-checking bench for the counter capture/compare array
`timescale 1ns/1ps
module tb_ccap_top;
  import ccap_pkg::*;
  logic clk, rst_n, wr, rd, t0, idle, irq, external_count_input, osc;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] lout, loe, ext_line, line_w;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] tb_mode [6] = '{8'h00, 8'h02, 8'h06, 8'h08, 8'h0a, 8'h88};
  int tb_cyc [6] = '{118, 38, 78, 8, 78, 8};
  logic [7:0] tb_exp [6] = '{8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h08, 8'h00};
  logic [7:0] cap_mode [3] = '{8'h21, 8'h10, 8'h31};
  // wire level: design drives when enabled, else the far side
  assign line_w = (loe & lout) | (~loe & ext_line);
  ccap_top dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .EXTERNAL_COUNT_INPUT(external_count_input), .T0_OVF(t0), .OSC_DIV8(osc), .CPU_IDLE(idle),
    .LINE_IN(line_w), .LINE_OUT(lout), .LINE_OE(loe), .IRQ(irq));
  ccap_ext_model ext (.clk(clk), .external_count_input(external_count_input), .osc(osc), .line(ext_line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g, input int t = 0);
    num_checks++;
    if ($isunknown(g) || g > e + t || g + t < e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
    end
    #1;
  endtask
  task automatic set_cnt(input logic [15:0] c);
    wr_reg(ADR_CNT_LO, c[7:0]);
    wr_reg(ADR_CNT_HI, c[15:8]);
  endtask
  task automatic chk_line(input logic [1:0] e);
    chk("line1", {6'h0, e}, {6'h0, loe[1], lout[1]});
  endtask
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
  initial begin
    {rst_n, wr, rd, t0, idle} = 5'h0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADR_CTRL, v);
    chk("ctrl", 8'h00, v);
    rd_reg(ADR_MODE, v);
    chk("mode", 8'h40, v);
    wr_reg(ADR_CNT_HI, 8'hab);
    rd_reg(ADR_CNT_LO, v);
    rd_reg(ADR_CNT_HI, v);
    chk("cnt_hi", 8'h00, v);
    wr_reg(ADR_MODE, 8'hc8);
    wr_reg(ADR_MMODE0 + 8'h2, 8'h4c);
    rd_reg(ADR_MODE, v);
    chk("mode_lock", 8'h40, v);
    rd_reg(ADR_MMODE0 + 8'h2, v);
    chk("mmode2_lock", 8'h00, v);
    wr_reg(ADR_MODE, 8'h00);
    wr_reg(ADR_MMODE0 + 8'h2, 8'h00);
    idle <= 1'b1;
    foreach (tb_mode[i]) begin
      wr_reg(ADR_CTRL, 8'h00);
      set_cnt(16'h0000);
      wr_reg(ADR_MODE, tb_mode[i]);
      wr_reg(ADR_CTRL, 8'h40);
      repeat (tb_cyc[i]) @(posedge clk);
      wr_reg(ADR_CTRL, 8'h00);
      rd_reg(ADR_CNT_LO, v);
      chk("count", tb_exp[i], v, 1);
    end
    idle <= 1'b0;
    wr_reg(ADR_MODE, 8'h05);
    wr_reg(ADR_CTRL, 8'h40);
    set_cnt(16'h12ff);
    fork
      tick(1);
      rd_reg(ADR_CNT_LO, v);
    join
    chk("cnt_lo", 8'hff, v);
    rd_reg(ADR_CNT_HI, v);
    chk("snap_hi", 8'h12, v);
    rd_reg(ADR_CNT_LO, v);
    chk("cnt_lo", 8'h00, v);
    set_cnt(16'hffff);
    tick(1);
    rd_reg(ADR_MODE, v);
    chk("ovf", 8'h25, v);
    chk("irq", 8'h01, {7'h0, irq});
    rd_reg(ADR_MODE, v);
    chk("ovf", 8'h25, v);
    wr_reg(ADR_MODE, 8'h04);
    chk("irq", 8'h00, {7'h0, irq});
    wr_reg(ADR_CTRL, 8'h40);
    for (int k = 0; k < 3; k++) begin
      wr_reg(ADR_MMODE0, cap_mode[k]);
      set_cnt({8'h12, 8'(k)});
      ext.set_line(0, 1'b1);
      rd_reg(ADR_CTRL, v);
      chk("rise", {7'h20, cap_mode[k][MM_CAPP]}, v);
      chk("irq", {7'h0, cap_mode[k][MM_CAPP] & cap_mode[k][MM_ECCF]}, {7'h0, irq});
      wr_reg(ADR_CTRL, 8'h40);
      ext.set_line(0, 1'b0);
      rd_reg(ADR_CTRL, v);
      chk("fall", {7'h20, cap_mode[k][MM_CAPN]}, v);
      wr_reg(ADR_CTRL, 8'h40);
    end
    rd_reg(ADR_CMP_LO0, v);
    chk("cap_lo", 8'h02, v);
    rd_reg(ADR_CMP_HI0, v);
    chk("cap_hi", 8'h12, v);
    ext.glitch(0);
    rd_reg(ADR_CTRL, v);
    chk("glitch", 8'h40, v);
    wr_reg(ADR_MMODE0 + 8'h1, 8'h49);
    wr_reg(ADR_CMP_LO0 + 8'h2, 8'h05);
    rd_reg(ADR_MMODE0 + 8'h1, v);
    chk("mmode1", 8'h09, v);
    wr_reg(ADR_CMP_HI0 + 8'h2, 8'h00);
    rd_reg(ADR_MMODE0 + 8'h1, v);
    chk("mmode1", 8'h49, v);
    set_cnt(16'h0000);
    tick(4);
    rd_reg(ADR_CTRL, v);
    chk("timer", 8'h40, v);
    tick(1);
    rd_reg(ADR_CTRL, v);
    chk("timer", 8'h42, v);
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(ADR_CTRL, 8'h40);
    wr_reg(ADR_MMODE0 + 8'h1, 8'h4c);
    set_cnt(16'h0000);
    tick(4);
    chk_line(2'b10);
    tick(1);
    chk_line(2'b11);
    wr_reg(ADR_MMODE0 + 8'h1, 8'hc2);
    set_cnt(16'hffff);
    tick(1);
    chk_line(2'b10);
    tick(5);
    chk_line(2'b11);
    wr_reg(ADR_MMODE0 + 8'h1, 8'h42);
    wr_reg(ADR_CMP_LO0 + 8'h2, 8'h03);
    wr_reg(ADR_CMP_HI0 + 8'h2, 8'h02);
    set_cnt(16'h00fe);
    tick(2);
    chk_line(2'b10);
    rd_reg(ADR_CMP_LO0 + 8'h2, v);
    chk("reload", 8'h02, v);
    tick(2);
    chk_line(2'b11);
    wr_reg(ADR_CMP_LO0 + 8'h2, 8'h04);
    wr_reg(ADR_CMP_HI0 + 8'h2, 8'h03);
    wr_reg(ADR_MMODE0 + 8'h1, 8'h46);
    set_cnt(16'h0000);
    tick(4);
    chk_line(2'b10);
    rd_reg(ADR_CMP_LO0 + 8'h2, v);
    chk("freq_lo", 8'h07, v);
    tick(3);
    chk_line(2'b11);
    finish_test();
  end
endmodule // tb_ccap_top

// ===== hdl/ccap_pkg.sv
// constants, register map and state types for the counter capture/compare array
package ccap_pkg;
  localparam int NUM_MOD = 3;
  // register indices on the 8-bit register port
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h01;
  localparam logic [7:0] ADR_CNT_LO = 8'h02;
  localparam logic [7:0] ADR_CNT_HI = 8'h03;
  localparam logic [7:0] ADR_MMODE0 = 8'h04;
  localparam logic [7:0] ADR_CMP_LO0 = 8'h08;
  localparam logic [7:0] ADR_CMP_HI0 = 8'h09;
  // counter_control_register fields
  localparam int CTL_RUN = 6;
  // counter_mode_register fields
  localparam int MD_IDLE_SUS = 7;
  localparam int MD_WDOG = 6;
  localparam int MD_CF = 5;
  localparam int MD_TB_LSB = 1;
  localparam int MD_ECF = 0;
  // module_mode_register fields
  localparam int MM_PWM16 = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_CAPP = 5;
  localparam int MM_CAPN = 4;
  localparam int MM_MAT = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_ECCF = 0;
  // timebase_select encodings
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0OVF = 3'h2;
  localparam logic [2:0] TB_ECI = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] LO_MAX = 8'hff;
  localparam logic [2:0] ADR_STEP_W = 3'h2;

  typedef enum logic [2:0] {
    CM_OFF, CM_CAP, CM_SWT, CM_HSO, CM_FREQ, CM_PWM8, CM_PWM16
  } ccap_mode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] snap;
    logic [3:0] div;
    logic eci_q;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic run;
    logic wdog;
    logic idle_sus;
    logic [2:0] tbsel;
    logic cf;
    logic ecf;
    logic [2:0] flags;
    logic [2:0][7:0] mmode;
    logic [2:0][15:0] cmp;
    logic [2:0] in_s1;
    logic [2:0] in_s2;
    logic [2:0] line_out;
    logic [2:0] line_oe;
    logic [7:0] rdata;
    logic irq;
  } ccap_state_t;
endpackage

// ===== hdl/ccap_top.sv
// counter capture/compare array: 16-bit counter, three capture/compare modules
// Notes on behaviour
// R1: one 16-bit counter, three modules, one line each
// R2: low-byte read snapshots high byte for next read
// R3: counter reads never disturb counting
// R4: timebase select picks one of six sources
// R5: count falling edges of external count input
// R6: external oscillator tick synchronised before use
// R7: wrap sets overflow flag, interrupt if enabled
// R8: overflow flag stays until software clears it
// R9: idle-suspend clear keeps counter running in idle
// R10: edge bits pick rising, falling or both capture
// R11: compare plus match is timer; toggle adds fast output
// R12: pwm with toggle is frequency, else 8/16-bit pwm
// R13: capture loads counter into module register pair
// R14: capture sets module flag, interrupt if enabled
// R15: module flags stay until software clears them
// R16: line levels must hold two clocks to count
// R17: timer mode flags equality of counter and register
// R18: low compare write clears, high write sets compare enable
// R19: software writes low compare byte before high
// R20: fast output inverts line on each match
// R21: per-module enable gates flag into interrupt
// R22: module 2 watchdog after reset restricts some writes
// R23: frequency mode toggles line and advances low byte
// R24: 8-bit pwm sets on match, clears and reloads on wrap
// R25: 16-bit pwm high on match, low on overflow
// R26: idle-suspend set halts counter while processor idles
// R27: all gated requests ORed into one interrupt
`timescale 1ns/1ps
module ccap_top
  import ccap_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic EXTERNAL_COUNT_INPUT,
  input wire logic T0_OVF,
  input wire logic OSC_DIV8,
  input wire logic CPU_IDLE,
  input wire logic [2:0] LINE_IN,
  output logic [2:0] LINE_OUT,
  output logic [2:0] LINE_OE,
  output logic IRQ
);
  ccap_state_t q, d;
  logic tick;
  logic [15:0] cnt_nx;
  logic ovf16, ovf8;
  logic [2:0] cap_ev;
  logic [2:0] rise, fall;

  function automatic ccap_mode_t decode(input logic [7:0] m);
    ccap_mode_t r;
    r = CM_OFF;
    if (!m[MM_MAT] && !m[MM_TOG] && !m[MM_PWM] && (m[MM_CAPP] || m[MM_CAPN]))
      r = CM_CAP;
    else if (m[MM_ECOM] && !m[MM_CAPP] && !m[MM_CAPN]) begin
      if (m[MM_PWM] && m[MM_TOG])
        r = CM_FREQ;
      else if (m[MM_PWM])
        r = m[MM_PWM16] ? CM_PWM16 : CM_PWM8;
      else if (m[MM_MAT])
        r = m[MM_TOG] ? CM_HSO : CM_SWT;
    end
    return r;
  endfunction

  always_comb begin
    logic [7:0] m;
    logic [7:0] lo_rel;
    logic m16, m8;
    logic [7:0] idx;
    ccap_mode_t md;
    m = 8'h00;
    lo_rel = 8'h00;
    m16 = 1'b0;
    m8 = 1'b0;
    idx = 8'h00;
    md = CM_OFF;
    d = q;
    tick = 1'b0;
    cap_ev = 3'h0;
    // timebase and synchronisers
    d.eci_q = EXTERNAL_COUNT_INPUT;
    d.osc_s1 = OSC_DIV8; // R6
    d.osc_s2 = q.osc_s1; // R6
    d.osc_s3 = q.osc_s2;
    d.div = (q.div == DIV12_LAST) ? 4'h0 : q.div + 4'h1;
    case (q.tbsel) // R4
      TB_DIV12: tick = (q.div == DIV12_LAST);
      TB_DIV4: tick = (q.div[1:0] == DIV4_LAST);
      TB_T0OVF: tick = T0_OVF;
      TB_ECI: tick = q.eci_q && !EXTERNAL_COUNT_INPUT; // R5
      TB_SYS: tick = 1'b1;
      TB_OSC8: tick = q.osc_s2 && !q.osc_s3; // R6
      default: tick = 1'b0;
    endcase
    // watchdog forces the counter on; idle-suspend halts it in idle
    tick = tick && (q.run || q.wdog) && !(q.idle_sus && CPU_IDLE); // R9 R26
    ovf16 = tick && (q.cnt == CNT_MAX);
    ovf8 = tick && (q.cnt[7:0] == LO_MAX);
    cnt_nx = tick ? q.cnt + 16'h0001 : q.cnt; // R1 R3
    d.cnt = cnt_nx;
    if (ovf16)
      d.cf = 1'b1; // R7
    // input sampling: a new level must be seen on two samples
    // in_s2 holds the accepted level, so a lone pulse leaves no false edge
    d.in_s1 = LINE_IN;
    d.in_s2 = (LINE_IN & q.in_s1) | (q.in_s2 & (LINE_IN | q.in_s1)); // R16
    rise = LINE_IN & q.in_s1 & ~q.in_s2; // R16
    fall = ~LINE_IN & ~q.in_s1 & q.in_s2; // R16
    for (int n = 0; n < NUM_MOD; n++) begin
      m = q.mmode[n];
      if (n == NUM_MOD - 1 && q.wdog)
        m = m | (8'h01 << MM_ECOM) | (8'h01 << MM_MAT);
      md = decode(m);
      if (n == NUM_MOD - 1 && q.wdog)
        md = CM_SWT; // R22
      m16 = tick && (cnt_nx == q.cmp[n]);
      d.line_oe[n] = (md == CM_HSO) || (md == CM_FREQ) || (md == CM_PWM8) ||
                     (md == CM_PWM16);
      case (md)
        CM_CAP: begin
          if ((m[MM_CAPP] && rise[n]) || (m[MM_CAPN] && fall[n])) begin // R10
            cap_ev[n] = 1'b1;
            d.cmp[n] = q.cnt; // R13
            d.flags[n] = 1'b1; // R14
          end
        end
        CM_SWT: begin
          if (m16)
            d.flags[n] = 1'b1; // R11 R17
        end
        CM_HSO: begin
          if (m16) begin
            d.line_out[n] = ~q.line_out[n]; // R20
            d.flags[n] = 1'b1;
          end
        end
        CM_FREQ: begin
          if (tick && (cnt_nx[7:0] == q.cmp[n][7:0])) begin // R12
            d.line_out[n] = ~q.line_out[n]; // R23
            d.cmp[n][7:0] = q.cmp[n][7:0] + q.cmp[n][15:8]; // R23
            if (m[MM_MAT])
              d.flags[n] = 1'b1;
          end
        end
        CM_PWM8: begin
          lo_rel = ovf8 ? q.cmp[n][15:8] : q.cmp[n][7:0];
          m8 = tick && (cnt_nx[7:0] == lo_rel);
          if (ovf8) begin
            d.line_out[n] = 1'b0; // R24
            d.cmp[n][7:0] = q.cmp[n][15:8]; // R24
          end
          // a match after reload wins so a zero high byte gives full duty
          if (m8) begin
            d.line_out[n] = 1'b1; // R24
            if (m[MM_MAT])
              d.flags[n] = 1'b1;
          end
        end
        CM_PWM16: begin
          if (ovf16)
            d.line_out[n] = 1'b0; // R25
          if (m16) begin
            d.line_out[n] = 1'b1; // R25
            if (m[MM_MAT])
              d.flags[n] = 1'b1;
          end
        end
        default: d.line_out[n] = q.line_out[n];
      endcase
    end
    // register writes; software clears flags, hardware sets win except on a module flag that was already set
    if (WR) begin
      case (ADDR)
        ADR_CTRL: begin
          d.run = WDATA[CTL_RUN];
          d.flags = (q.flags & WDATA[2:0]) | (d.flags & ~q.flags); // R15
        end
        ADR_MODE: begin
          d.ecf = WDATA[MD_ECF];
          d.wdog = WDATA[MD_WDOG];
          d.cf = (q.cf & WDATA[MD_CF]) | ovf16; // R8
          if (!q.wdog) begin // R22
            d.idle_sus = WDATA[MD_IDLE_SUS];
            d.tbsel = WDATA[MD_TB_LSB +: 3];
          end
        end
        ADR_CNT_LO: if (!q.wdog) d.cnt[7:0] = WDATA; // R22
        ADR_CNT_HI: if (!q.wdog) d.cnt[15:8] = WDATA; // R22
        default: begin
          for (int n = 0; n < NUM_MOD; n++) begin
            idx = ADR_MMODE0 + 8'(n);
            if (ADDR == idx && !(n == NUM_MOD - 1 && q.wdog)) // R22
              d.mmode[n] = WDATA;
            idx = ADR_CMP_LO0 + 8'(ADR_STEP_W * 3'(n));
            if (ADDR == idx) begin
              d.cmp[n][7:0] = WDATA;
              d.mmode[n][MM_ECOM] = 1'b0; // R18
            end
            if (ADDR == idx + 8'h01) begin
              d.cmp[n][15:8] = WDATA;
              d.mmode[n][MM_ECOM] = 1'b1; // R18
            end
          end
        end
      endcase
    end
    // register reads, data one cycle later
    if (RD) begin
      d.rdata = 8'h00;
      case (ADDR)
        ADR_CTRL: d.rdata = {1'b0, q.run, 3'h0, q.flags};
        ADR_MODE: d.rdata = {q.idle_sus, q.wdog, q.cf, 1'b0, q.tbsel, q.ecf};
        ADR_CNT_LO: begin
          d.rdata = q.cnt[7:0];
          d.snap = q.cnt[15:8]; // R2
        end
        ADR_CNT_HI: d.rdata = q.snap; // R2
        default: begin
          for (int n = 0; n < NUM_MOD; n++) begin
            idx = ADR_MMODE0 + 8'(n);
            if (ADDR == idx)
              d.rdata = q.mmode[n];
            idx = ADR_CMP_LO0 + 8'(ADR_STEP_W * 3'(n));
            if (ADDR == idx)
              d.rdata = q.cmp[n][7:0];
            if (ADDR == idx + 8'h01)
              d.rdata = q.cmp[n][15:8];
          end
        end
      endcase
    end
    d.irq = (d.cf && d.ecf) || // R7 R27
            (|(d.flags & {d.mmode[2][MM_ECCF], d.mmode[1][MM_ECCF],
                          d.mmode[0][MM_ECCF]})); // R14 R21 R27
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.wdog <= 1'b1; // R22
    end else begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign LINE_OUT = q.line_out;
  assign LINE_OE = q.line_oe;
  assign IRQ = q.irq;

  // checks
  logic [7:0] wm1;
  assign wm1 = q.mmode[1];

  a_snap_latch: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
    RD && ADDR == ADR_CNT_LO |=> q.snap == $past(q.cnt[15:8]))
    else $error("snapshot not taken on low byte read");
  a_snap_read: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
    RD && ADDR == ADR_CNT_HI |=> RDATA == $past(q.snap))
    else $error("high byte read does not return snapshot");
  a_read_no_stall: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
    RD && !WR && tick |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("read disturbed counting");
  a_ovf_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R7
    ovf16 && !WR |=> q.cf && q.cnt == 16'h0000)
    else $error("overflow flag not set on wrap");
  a_cf_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
    q.cf && !(WR && ADDR == ADR_MODE) |=> q.cf)
    else $error("overflow flag cleared without software");
  a_idle_halt: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R26
    q.idle_sus && CPU_IDLE && !WR |=> $stable(q.cnt))
    else $error("counter ran while suspended in idle");
  a_capture_load: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R13
    cap_ev[0] && !WR |=> q.cmp[0] == $past(q.cnt) && q.flags[0])
    else $error("capture did not load counter or set flag");
  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R15
    q.flags[1] && !(WR && ADDR == ADR_CTRL) |=> q.flags[1])
    else $error("module flag cleared without software");
  a_ecom_low: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R18
    WR && ADDR == ADR_CMP_LO0 + 8'h02 |=> !q.mmode[1][MM_ECOM])
    else $error("low compare write left compare enabled");
  a_hso_toggle: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R20
    decode(wm1) == CM_HSO && tick && cnt_nx == q.cmp[1] && !WR
    |=> LINE_OUT[1] != $past(LINE_OUT[1]))
    else $error("fast output did not toggle on match");
  a_irq_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R21
    IRQ == ((q.cf && q.ecf) || (|(q.flags & {q.mmode[2][MM_ECCF],
      q.mmode[1][MM_ECCF], q.mmode[0][MM_ECCF]}))))
    else $error("interrupt does not match gated flags");
  a_wdog_lock: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R22
    q.wdog && WR && ADDR == ADR_MODE |=> $stable(q.tbsel) && $stable(q.idle_sus))
    else $error("timebase changed under watchdog");
  a_mod2_lock: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R22
    q.wdog && WR && ADDR == ADR_MMODE0 + 8'h02 |=> $stable(q.mmode[2]))
    else $error("module 2 mode changed under watchdog");
  a_sys_count: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
    q.tbsel == TB_SYS && q.run && !q.idle_sus && !WR |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("system clock timebase missed a count");
  a_eci_count: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
    q.tbsel == TB_ECI && q.run && !q.idle_sus && q.eci_q && !EXTERNAL_COUNT_INPUT && !WR
    |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("falling edge of count input not counted");
  a_osc_sync: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
    q.tbsel == TB_OSC8 && tick |-> $past(OSC_DIV8, 2) && !$past(OSC_DIV8, 3))
    else $error("oscillator tick used before synchronisation");
  a_line_filter: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R16
    !$stable(LINE_IN[0]) |-> !cap_ev[0])
    else $error("capture on a level seen only once");
  a_cap_edge: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
    cap_ev[0] |-> (q.mmode[0][MM_CAPP] && LINE_IN[0]) ||
      (q.mmode[0][MM_CAPN] && !LINE_IN[0]))
    else $error("capture on an unselected edge");
  a_cap_irq: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R14
    cap_ev[0] && q.mmode[0][MM_ECCF] && !WR |=> IRQ)
    else $error("capture with enabled flag gave no interrupt");
  a_swt_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R17
    decode(wm1) == CM_SWT && tick && cnt_nx == q.cmp[1] |=> q.flags[1])
    else $error("timer match did not set module flag");
  a_freq_step: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R23
    decode(wm1) == CM_FREQ && tick && cnt_nx[7:0] == q.cmp[1][7:0] && !WR
    |=> q.cmp[1][7:0] == $past(q.cmp[1][7:0]) + $past(q.cmp[1][15:8]) &&
        LINE_OUT[1] != $past(LINE_OUT[1]))
    else $error("frequency output did not toggle and advance");
  a_pwm8_reload: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R24
    decode(wm1) == CM_PWM8 && ovf8 && !WR |=> q.cmp[1][7:0] == $past(q.cmp[1][15:8]))
    else $error("8-bit pwm did not reload low compare byte");
  a_pwm16_low: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R25
    decode(wm1) == CM_PWM16 && ovf16 && q.cmp[1] != 16'h0000 && !WR |=> !LINE_OUT[1])
    else $error("16-bit pwm line not low after overflow");

  c_overflow: cover property (@(posedge REF_CLK) disable iff (!RST_N) ovf16);
  c_capture: cover property (@(posedge REF_CLK) disable iff (!RST_N) |cap_ev);
  c_pwm_rise: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    decode(wm1) == CM_PWM8 && $rose(LINE_OUT[1]));
  c_freq_toggle: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    decode(wm1) == CM_FREQ && $changed(LINE_OUT[1]));
  c_timer_flag: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    decode(wm1) == CM_SWT && $rose(q.flags[1]));
endmodule // ccap_top
